// ===== rtl/pmx_defs.vh
// constants for the port 3/4/5 pin function multiplexer
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH

// register byte offsets
`define PMX_OFF_DIR 12'h000
`define PMX_OFF_OUT 12'h004
`define PMX_OFF_ODR 12'h008
`define PMX_OFF_FEN 12'h00C
`define PMX_OFF_PIN 12'h010
`define PMX_OFF_STAT 12'h014

// reset values
`define PMX_RST_DIR 10'h000
`define PMX_RST_OUT 10'h000
`define PMX_RST_ODR 8'h00
`define PMX_RST_FEN 8'h00

// function enable bit positions
`define PMX_FEN_TX0 0
`define PMX_FEN_CK0 1
`define PMX_FEN_TX1 2
`define PMX_FEN_CK1 3
`define PMX_FEN_PG0 4
`define PMX_FEN_PG1 5

// pin vector bit positions: 0 = port3 bit7, 1..8 = port4 bits 0..7, 9 = port5 bit0
`define PMX_P37 0
`define PMX_P4_BASE 1
`define PMX_P50 9
`define PMX_NPIN 10

// operating mode pin code for single chip mode
`define PMX_MODE_SINGLE 3'h3

// mode capture count: the strap sync chain holds the pins from this count on
`define PMX_MODE_CAPTURE 2'h2
`define PMX_MODE_READY 2'h3

`endif

// ===== rtl/pmx_sync.v
// two flip-flop synchroniser for a vector of pin inputs
`default_nettype none

module pmx_sync #(
   parameter W = 10
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // asynchronous in, synchronised out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   reg [W-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // pmx_sync

`default_nettype wire

// ===== rtl/pmx_top.v
// pin function multiplexer for port3 bit7, port4 and port5 bit0, with APB registers
// Behaviour
// - single chip: port3_bit7 is GPIO; external bus: drives bus clock
// - each port4 GPIO pin push-pull or open-drain by its own control bit
// - async tx pins carry serial data only when channel data output enabled
// - async clock pins drive clock only when clock output enabled
// - port4 bits 6,7 carry pulse outputs when enabled, else GPIO
// - async rx pins always sampled for the channel, whatever the output setting
// - port5 bit0 continuously feeds the sync serial channel 0 input
`default_nettype none
`include "pmx_defs.vh"

module pmx_top (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // operating mode pins
   input wire op_mode_pin_a,
   input wire op_mode_pin_b,
   input wire op_mode_pin_c,
   // pins: index 0 port3_bit7, 1..8 port4_bit0..7, 9 port5_bit0
   input wire [9:0] pin_in,
   output reg [9:0] pin_out,
   output reg [9:0] pin_oe_n,
   // peripheral outputs
   input wire bus_clk_out,
   input wire async0_tx_out,
   input wire async0_clk_out,
   input wire async1_tx_out,
   input wire async1_clk_out,
   input wire pulse_gen_out_a,
   input wire pulse_gen_out_b,
   // peripheral inputs
   output reg async0_rx_in,
   output reg async0_clk_in,
   output reg async1_rx_in,
   output reg async1_clk_in,
   output reg sync_serial0_rx_in,
   // mode status
   output reg ext_bus_mode
);

   // ==========================================================
   // registers
   reg [9:0] dir_q;
   reg [9:0] out_q;
   reg [7:0] odr_q;
   reg [7:0] fen_q;
   reg [2:0] mode_q;
   reg [1:0] mode_cnt_q;
   wire [2:0] mode_sync;
   wire [9:0] pin_sync;

   // ==========================================================
   // pin and mode input synchronisers
   pmx_sync #(.W(10)) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   pmx_sync #(.W(3)) u_mode_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({op_mode_pin_c, op_mode_pin_b, op_mode_pin_a}),
      .sync_out(mode_sync)
   );
   // ==========================================================
   // mode capture: pins are static, sample once the sync chain is primed;
   // sampling earlier would catch the chain's reset zeros, not the straps
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `PMX_MODE_SINGLE;
         mode_cnt_q <= 2'h0;
         ext_bus_mode <= 1'b0;
      end else begin
         if (mode_cnt_q != `PMX_MODE_READY) begin
            mode_cnt_q <= mode_cnt_q + 2'h1;
         end
         if (mode_cnt_q == `PMX_MODE_CAPTURE) begin
            mode_q <= mode_sync;
         end
         ext_bus_mode <= (mode_cnt_q == `PMX_MODE_READY) &&
                         (mode_q != `PMX_MODE_SINGLE);
      end
   end

   // ==========================================================
   // apb slave, zero wait states
   wire wr_en = psel && penable && pwrite;
   wire rd_sel = psel && !penable && !pwrite;
   wire addr_ok = (paddr == `PMX_OFF_DIR) || (paddr == `PMX_OFF_OUT) ||
                  (paddr == `PMX_OFF_ODR) || (paddr == `PMX_OFF_FEN) ||
                  (paddr == `PMX_OFF_PIN) || (paddr == `PMX_OFF_STAT);

   // control registers; reset leaves every pin an input
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= `PMX_RST_DIR;
         out_q <= `PMX_RST_OUT;
         odr_q <= `PMX_RST_ODR;
         fen_q <= `PMX_RST_FEN;
      end else if (wr_en) begin
         case (paddr)
            `PMX_OFF_DIR: dir_q <= pwdata[9:0];
            `PMX_OFF_OUT: out_q <= pwdata[9:0];
            `PMX_OFF_ODR: odr_q <= pwdata[7:0];
            `PMX_OFF_FEN: fen_q <= {2'h0, pwdata[5:0]};
            default: ;
         endcase
      end
   end

   // read data registered in setup so it is valid in access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_sel) begin
            case (paddr)
               `PMX_OFF_DIR: prdata <= {22'h000000, dir_q};
               `PMX_OFF_OUT: prdata <= {22'h000000, out_q};
               `PMX_OFF_ODR: prdata <= {24'h000000, odr_q};
               `PMX_OFF_FEN: prdata <= {24'h000000, fen_q};
               `PMX_OFF_PIN: prdata <= {22'h000000, pin_sync};
               `PMX_OFF_STAT: prdata <= {28'h0000000, mode_q, ext_bus_mode};
               default: prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // per-pin function selection
   reg [9:0] fn_en; // peripheral owns the pin
   reg [9:0] fn_val; // peripheral output level
   always @* begin
      fn_en = 10'h000;
      fn_val = 10'h000;
      fn_en[`PMX_P37] = ext_bus_mode;
      fn_val[`PMX_P37] = bus_clk_out;
      fn_en[`PMX_P4_BASE + 1] = fen_q[`PMX_FEN_TX0];
      fn_val[`PMX_P4_BASE + 1] = async0_tx_out;
      fn_en[`PMX_P4_BASE + 2] = fen_q[`PMX_FEN_CK0];
      fn_val[`PMX_P4_BASE + 2] = async0_clk_out;
      fn_en[`PMX_P4_BASE + 4] = fen_q[`PMX_FEN_TX1];
      fn_val[`PMX_P4_BASE + 4] = async1_tx_out;
      fn_en[`PMX_P4_BASE + 5] = fen_q[`PMX_FEN_CK1];
      fn_val[`PMX_P4_BASE + 5] = async1_clk_out;
      fn_en[`PMX_P4_BASE + 6] = fen_q[`PMX_FEN_PG0];
      fn_val[`PMX_P4_BASE + 6] = pulse_gen_out_a;
      fn_en[`PMX_P4_BASE + 7] = fen_q[`PMX_FEN_PG1];
      fn_val[`PMX_P4_BASE + 7] = pulse_gen_out_b;
   end

   // open-drain applies only to port4 pins in gpio use
   wire [9:0] od_vec = {1'b0, odr_q, 1'b0};

   // registered pin drivers, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < `PMX_NPIN; gi = gi + 1) begin : g_pin
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out[gi] <= 1'b0;
               pin_oe_n[gi] <= 1'b1;
            end else if (fn_en[gi]) begin
               pin_out[gi] <= fn_val[gi];
               pin_oe_n[gi] <= 1'b0;
            end else if (od_vec[gi]) begin
               // open drain: drive only low, release for high
               pin_out[gi] <= 1'b0;
               pin_oe_n[gi] <= !(dir_q[gi] && !out_q[gi]);
            end else begin
               pin_out[gi] <= out_q[gi];
               pin_oe_n[gi] <= !dir_q[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // peripheral inputs: always fed from the pin, whatever the driver
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async0_rx_in <= 1'b1;
         async1_rx_in <= 1'b1;
         async0_clk_in <= 1'b1;
         async1_clk_in <= 1'b1;
         sync_serial0_rx_in <= 1'b1;
      end else begin
         async0_rx_in <= pin_sync[`PMX_P4_BASE];
         async1_rx_in <= pin_sync[`PMX_P4_BASE + 3];
         async0_clk_in <= pin_sync[`PMX_P4_BASE + 2];
         async1_clk_in <= pin_sync[`PMX_P4_BASE + 5];
         sync_serial0_rx_in <= pin_sync[`PMX_P50];
      end
   end

endmodule // pmx_top

`default_nettype wire

// ===== sim/pmx_per_model.sv
// model of the peripheral units feeding the mux
`default_nettype none
module pmx_per_model (
   // clock
   input wire logic pclk,
   // bus clk, tx0, clk0, tx1, clk1, pulse a, pulse b
   output logic [6:0] per
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // odd step, so no output sits still for long
   initial per = 7'h15;
   always @(posedge pclk) per <= per + 7'h2B;
endmodule // pmx_per_model
`default_nettype wire

// ===== sim/pmx_top_asserts.sv
// concurrent checks on the pin multiplexer ports
`default_nettype none
module pmx_top_asserts (
   // clock, reset, apb answer
   input wire logic pclk, presetn, pready,
   // mode straps and bus clock source
   input wire logic op_mode_pin_a, op_mode_pin_b, op_mode_pin_c, bus_clk_out,
   // pins
   input wire logic [9:0] pin_in, pin_out, pin_oe_n,
   // peripheral inputs and mode
   input wire logic async0_rx_in, async1_rx_in, async0_clk_in, async1_clk_in,
   input wire logic sync_serial0_rx_in, ext_bus_mode
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_q;
   // ==========================================
   // edges since reset, the sync chain is unprimed at first
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) cnt_q <= 3'h0;
      else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence settled_s; cnt_q == 3'h7; endsequence
   chk_rx0_follow: assert property (cnt_q > 3 |-> async0_rx_in == $past(pin_in[1], 3))
      else $error("rx0 input not following pin");
   chk_rx1_follow: assert property (cnt_q > 3 |-> async1_rx_in == $past(pin_in[4], 3))
      else $error("rx1 input not following pin");
   chk_sync_rx: assert property (cnt_q > 3 |-> sync_serial0_rx_in == $past(pin_in[9], 3))
      else $error("sync rx input not following pin");
   chk_clk_follow: assert property (cnt_q > 3 |-> async0_clk_in == $past(pin_in[3], 3)
      && async1_clk_in == $past(pin_in[6], 3)) else $error("clock inputs not following pins");
   chk_mode_strap: assert property (cnt_q > 4 |-> ext_bus_mode ==
      ({op_mode_pin_c, op_mode_pin_b, op_mode_pin_a} != 3'h3)) else $error("mode strap wrong");
   chk_bus_clk: assert property (settled_s ##0 ext_bus_mode |-> !pin_oe_n[0]
      && pin_out[0] == $past(bus_clk_out)) else $error("bus clock not on pin");
   chk_reset_idle: assert property (cnt_q == 3'h1 |-> (pin_oe_n == 10'h3FF) [*2])
      else $error("pins driven after reset");
   chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
endmodule // pmx_top_asserts
bind pmx_top pmx_top_asserts pmx_top_asserts_inst (.pclk, .presetn, .pready, .op_mode_pin_a,
   .op_mode_pin_b, .op_mode_pin_c, .bus_clk_out, .pin_in, .pin_out, .pin_oe_n, .async0_rx_in,
   .async1_rx_in, .async0_clk_in, .async1_clk_in, .sync_serial0_rx_in, .ext_bus_mode);
`default_nettype wire

// ===== sim/pmx_top_bench.sv
// self-checking bench for the pin function multiplexer
`default_nettype none
module pmx_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, ext;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [9:0] pin_in = 0, pin_out, pin_oe_n;
   logic [6:0] per, p;
   logic [2:0] mode = 3'h3;
   logic async0_rx_in, async1_rx_in, async0_clk_in, async1_clk_in;
   logic sync_serial0_rx_in, ext_bus_mode;
   int num_errors = 0, check_count = 0, seed = 3;
   int v[4];
   int fp[6] = '{2, 3, 5, 6, 7, 8};
   pmx_top pmx_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .op_mode_pin_a(mode[0]), .op_mode_pin_b(mode[1]), .op_mode_pin_c(mode[2]),
      .pin_in, .pin_out, .pin_oe_n, .bus_clk_out(per[0]), .async0_tx_out(per[1]),
      .async0_clk_out(per[2]), .async1_tx_out(per[3]), .async1_clk_out(per[4]),
      .pulse_gen_out_a(per[5]), .pulse_gen_out_b(per[6]), .async0_rx_in, .async0_clk_in,
      .async1_rx_in, .async1_clk_in, .sync_serial0_rx_in, .ext_bus_mode);
   pmx_per_model pmx_per_model_inst (.pclk, .per);
   always #2.5 pclk = ~pclk;
   // ==========================================
   // apb master, holds the request until ready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task chk(input logic [31:0] seen, want, input string m);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // expected drive: functions beat gpio, open drain only releases
   function automatic logic [19:0] pins_exp(input logic [6:0] q);
      logic [9:0] e, o;
      e = 10'h3FF;
      o = 0;
      for (int i = 0; i < 10; i++)
         if (v[0][i]) begin
            e[i] = (i > 0 && i < 9 && v[2][i-1]) ? v[1][i] : 1'b0; // per pin open drain
            o[i] = v[1][i] & ~e[i];
         end
      for (int k = 0; k < 6; k++)
         if (v[3][k]) begin
            e[fp[k]] = 0; // function drives pin
            o[fp[k]] = q[k + 1];
         end
      if (ext) begin
         e[0] = 0; // bus clock on pin
         o[0] = q[0];
      end
      return {e, o};
   endfunction
   task test_done;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // one pass for each of two mode strap settings (3'h3 and 3'h5), each behind its own reset
   initial begin
      for (int m = 0; m < 2; m++) begin
         ext = m;
         @(posedge pclk);
         presetn <= 0;
         mode <= m ? 3'h5 : 3'h3; // strap set only under reset
         repeat (12) @(posedge pclk);
         presetn <= 1;
         chk(pin_oe_n, 10'h3FF, "pins driven in reset"); // all released
         for (int k = 0; k < 6; k++) begin
            apb(0, k * 4, 0);
            chk(rd, k == 5 ? {mode, ext} : k == 4 ? pin_in : 0, "reset value"); // idle
         end
         apb(1, 12'h018, 32'h5A);
         apb(0, 12'h018, 0);
         chk(rd, 0, "unmapped read data");
         chk(err, 1, "unmapped access");
         repeat (16) begin
            @(posedge pclk);
            pin_in <= $random(seed);
            // async rx pins never made outputs
            v = '{$random(seed) & 32'h3ED, $random(seed) & 32'h3FF,
               $random(seed) & 32'hFF, $random(seed) & 32'h3F};
            for (int k = 0; k < 4; k++) apb(1, k * 4, v[k]);
            for (int k = 0; k < 5; k++) begin
               apb(0, k * 4, 0);
               chk(rd, k == 4 ? pin_in : v[k], "readback"); // control and pins
               chk(err, 0, "mapped slave error");
            end
            @(posedge pclk);
            p = per;
            #1;
            chk({pin_oe_n, pin_out & ~pin_oe_n}, pins_exp(p), "pin drive"); // mux
            chk({async0_rx_in, async1_rx_in, async0_clk_in, async1_clk_in, sync_serial0_rx_in},
               {pin_in[1], pin_in[4], pin_in[3], pin_in[6], pin_in[9]}, "pin sampling");
         end
         $display("mode %0d done", mode);
      end
      test_done;
   end
   // watchdog, the run needs well under 20 us
   initial begin
      #50000;
      num_errors++;
      test_done;
   end
endmodule // pmx_top_bench
`default_nettype wire
